// ==== hw/adsr_cfg.svh ====
// Constants for the serial command and readout block of the sensor ADC.
// Assumes inclusion by the package and the design files by bare name.
`ifndef ADSR_CFG_SVH
`define ADSR_CFG_SVH
`define ADSR_OP_RDATA 4'h1
`define ADSR_OP_REGISTER_READ_CMD 4'h2
`define ADSR_OP_REGISTER_WRITE_CMD 4'h4
`define ADSR_OP_RESET 7'h03
`define ADSR_OP_SYNC 7'h04
`define ADSR_OP_PDOWN 7'h01
`define ADSR_REG_CFG0 2'h0
`define ADSR_REG_CFG1 2'h1
`define ADSR_REG_CFG2 2'h2
`define ADSR_REG_CFG3 2'h3
`define ADSR_REG_RST 8'h00
`define ADSR_CFG3_MASK 8'hfe
`define ADSR_GAIN_HI 3
`define ADSR_GAIN_LO 1
`define ADSR_BYPASS_BIT 0
`define ADSR_RDYSEL_BIT 1
`define ADSR_GAIN_AMP_MIN 3'h3
`define ADSR_RESULT_BITS 24
`define ADSR_BYTE_BITS 8
`define ADSR_FLUSH_BITS 8
`endif

// ==== hw/adsr_pkg.sv ====
// Types shared by the serial readout block and its register store.
// Assumes adsr_cfg.svh is on the include path.
`include "adsr_cfg.svh"
package adsr_pkg;
  typedef enum logic [2:0] {
    ADSR_IDLE = 3'b000,
    ADSR_STREAM = 3'b001,
    ADSR_RDATA = 3'b010,
    ADSR_REGISTER_READ_CMD = 3'b011,
    ADSR_REGISTER_WRITE_CMD = 3'b100,
    ADSR_FLUSH = 3'b101
  } adsr_state_t;

  // Register write request from the command logic
  typedef struct packed {
    logic en;
    logic [1:0] addr;
    logic [7:0] data;
  } adsr_wr_t;

  // Analog-side controls derived from the registers
  typedef struct packed {
    logic [7:0] gain;
    logic amp_enable;
    logic ready_on_output_select;
  } adsr_ctl_t;
endpackage

// ==== hw/adsr_regs.sv ====
// Four 8-bit configuration registers with registered read data.
// Assumes writes arrive as single-cycle strobes from the serial logic.
`timescale 1ns/1ps
`include "adsr_cfg.svh"
module adsr_regs #(
  parameter int NREG = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input adsr_pkg::adsr_wr_t wr,
  input wire logic [1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [8*NREG-1:0] all_regs
);
  initial begin
    if (NREG != 4) $error("adsr_regs supports exactly four registers");
  end

  logic [7:0] reg_ff [NREG];
  logic [7:0] nxt_reg [NREG];
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  // Per-register next value; reserved bit of register 3 is never stored
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_comb begin
        nxt_reg[gi] = reg_ff[gi];
        if (soft_rst) begin
          nxt_reg[gi] = `ADSR_REG_RST;
        end else if (wr.en && wr.addr == 2'(gi)) begin
          nxt_reg[gi] = (2'(gi) == `ADSR_REG_CFG3) ? (wr.data & `ADSR_CFG3_MASK)
                                                    : wr.data;
        end
      end
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          reg_ff[gi] <= `ADSR_REG_RST;
        end else begin
          reg_ff[gi] <= nxt_reg[gi];
        end
      end
      assign all_regs[8*gi +: 8] = reg_ff[gi];
    end
  endgenerate

  // Read data come out of a register, one cycle after the address
  always_comb begin
    nxt_rd_data = reg_ff[rd_addr];
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_ff <= `ADSR_REG_RST;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end
  assign rd_data = rd_data_ff;
endmodule

// ==== hw/adsr_serial.sv ====
// Serial command decoder and result readout of a sensor ADC.
// Assumes cs_n, sclk and din are synchronous to mclk and sclk is slow.
`timescale 1ns/1ps
`include "adsr_cfg.svh"
module adsr_serial #(
  parameter int RES_BITS = `ADSR_RESULT_BITS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  output logic data_ready_n_pin,
  input wire logic conv_done,
  input wire logic [RES_BITS-1:0] conv_data,
  output logic filter_restart,
  output logic start_sync,
  output logic power_down,
  output adsr_pkg::adsr_ctl_t ctl,
  output logic [7:0] cfg1,
  output logic [7:0] cfg2,
  output logic [7:0] cfg3
);
  initial begin
    if (RES_BITS != `ADSR_RESULT_BITS) $error("result width must be 24");
  end

  adsr_pkg::adsr_state_t st_ff, nxt_st;
  logic sclk_ff, cs_n_ff;
  logic [RES_BITS-1:0] buf_ff, nxt_buf, shf_ff, nxt_shf;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [4:0] bit_ff, nxt_bit;
  logic [2:0] cbit_ff, nxt_cbit;
  logic [1:0] addr_ff, nxt_addr, left_ff, nxt_left;
  logic new_ff, nxt_new, rdy_ff, nxt_rdy, dout_ff, nxt_dout;
  logic pd_ff, nxt_pd;
  logic [7:0] rbyte_ff, nxt_rbyte;
  logic [1:0] rd_addr;
  logic [7:0] rd_data;
  logic [31:0] all_regs;
  adsr_pkg::adsr_wr_t wr;
  logic soft_rst, rise, fall;
  logic [7:0] cmd_full;
  logic [2:0] gain_code;

  assign rise = sclk && !sclk_ff && !cs_n;
  assign fall = !sclk && sclk_ff && !cs_n;
  assign cmd_full = {cmd_ff[6:0], din};

  adsr_regs #(.NREG(4)) u_regs (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .soft_rst(soft_rst),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .all_regs(all_regs)
  );

  // Edge detect; inputs are treated as already synchronous
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
    end else begin
      sclk_ff <= sclk;
      cs_n_ff <= cs_n;
    end
  end

  // Command byte, result, register and ready control
  always_comb begin
    nxt_st = st_ff;
    nxt_buf = buf_ff;
    nxt_shf = shf_ff;
    nxt_cmd = cmd_ff;
    nxt_bit = bit_ff;
    nxt_cbit = cbit_ff;
    nxt_addr = addr_ff;
    nxt_left = left_ff;
    nxt_new = new_ff;
    nxt_rdy = rdy_ff;
    nxt_dout = dout_ff;
    nxt_pd = pd_ff;
    nxt_rbyte = rbyte_ff;
    wr = '0;
    soft_rst = 1'b0;
    filter_restart = 1'b0;
    start_sync = 1'b0;
    // Registered read port runs a cycle behind: aim it at the byte needed next
    rd_addr = (st_ff == adsr_pkg::ADSR_REGISTER_READ_CMD) ? addr_ff + 2'd1 : cmd_ff[2:1];
    // New result: buffer updates, ready flag and dedicated pin fall; a read in flight keeps its shifter
    if (conv_done) begin
      nxt_buf = conv_data;
      nxt_new = 1'b1;
      nxt_rdy = 1'b0;
    end
    if (cs_n) begin
      // Deselect resets framing; ready on dedicated pin is unaffected
      nxt_st = adsr_pkg::ADSR_IDLE;
      nxt_cbit = '0;
      nxt_bit = '0;
    end else if (!cs_n && cs_n_ff) begin
      // Chip select fall: ready level driven at once if register 3 selects it, else high; a fresh result streams
      nxt_dout = all_regs[8*3+`ADSR_RDYSEL_BIT] ? nxt_rdy : 1'b1;
      if (nxt_new) begin
        nxt_st = adsr_pkg::ADSR_STREAM;
        nxt_shf = nxt_buf;
        nxt_new = 1'b0;
      end
    end else if (rise) begin
      // Data change on rising edges, MSB first
      case (st_ff)
        adsr_pkg::ADSR_STREAM, adsr_pkg::ADSR_RDATA: begin
          nxt_dout = shf_ff[RES_BITS-1];
          nxt_shf = {shf_ff[RES_BITS-2:0], 1'b0};
          nxt_bit = bit_ff + 5'd1;
        end
        adsr_pkg::ADSR_REGISTER_READ_CMD: begin
          nxt_dout = rbyte_ff[7];
          nxt_rbyte = {rbyte_ff[6:0], 1'b0};
        end
        adsr_pkg::ADSR_FLUSH: begin
          nxt_dout = 1'b1;
        end
        adsr_pkg::ADSR_REGISTER_WRITE_CMD: begin
          // A write sent inside a stream read must not stall the result bits
          if (bit_ff != 5'd0 && bit_ff != 5'(`ADSR_RESULT_BITS)) begin
            nxt_dout = shf_ff[RES_BITS-1];
            nxt_shf = {shf_ff[RES_BITS-2:0], 1'b0};
            nxt_bit = bit_ff + 5'd1;
          end else begin
            nxt_dout = all_regs[8*3+`ADSR_RDYSEL_BIT] ? rdy_ff : 1'b1;
          end
        end
        default: begin
          nxt_dout = all_regs[8*3+`ADSR_RDYSEL_BIT] ? rdy_ff : 1'b1;
        end
      endcase
    end else if (fall) begin
      nxt_cmd = cmd_full;
      nxt_cbit = cbit_ff + 3'd1;
      case (st_ff)
        adsr_pkg::ADSR_RDATA: begin
          nxt_cbit = '0;
          if (bit_ff == 5'(`ADSR_RESULT_BITS)) begin
            nxt_st = adsr_pkg::ADSR_FLUSH;
            nxt_bit = '0;
            nxt_rdy = !nxt_new;
          end
        end
        adsr_pkg::ADSR_REGISTER_READ_CMD: begin
          if (cbit_ff == 3'd7) begin
            nxt_addr = addr_ff + 2'd1;
            rd_addr = addr_ff + 2'd1;
            nxt_rbyte = rd_data;
            if (left_ff == 2'd0) begin
              nxt_st = adsr_pkg::ADSR_IDLE;
            end else begin
              nxt_left = left_ff - 2'd1;
            end
          end
        end
        adsr_pkg::ADSR_REGISTER_WRITE_CMD: begin
          if (cbit_ff == 3'd7) begin
            wr.en = 1'b1;
            wr.addr = addr_ff;
            wr.data = cmd_full;
            nxt_addr = addr_ff + 2'd1;
            if (left_ff == 2'd0) begin
              filter_restart = 1'b1;
              // Result fully shifted under the write: go on to the flush clocks
              if (bit_ff == 5'(`ADSR_RESULT_BITS)) begin
                nxt_st = adsr_pkg::ADSR_FLUSH;
                nxt_bit = '0;
                nxt_rdy = !nxt_new;
              end else if (bit_ff != 5'd0) begin
                nxt_st = adsr_pkg::ADSR_STREAM;
              end else begin
                nxt_st = adsr_pkg::ADSR_IDLE;
              end
            end else begin
              nxt_left = left_ff - 2'd1;
            end
          end
        end
        default: begin
          // Commands taken on 8-bit boundaries; all-zero input is no command
          if (st_ff == adsr_pkg::ADSR_STREAM && bit_ff == 5'(`ADSR_RESULT_BITS)) begin
            nxt_st = adsr_pkg::ADSR_FLUSH;
            nxt_bit = '0;
            nxt_rdy = !nxt_new; // A result landing mid-read keeps ready low
          end
          if (cbit_ff == 3'd7) begin
            nxt_cbit = '0;
            // A command in the last result byte leaves that read intact
            if (cmd_full[7:4] == `ADSR_OP_RDATA) begin
              nxt_st = adsr_pkg::ADSR_RDATA;
              nxt_shf = nxt_buf;
              nxt_bit = '0;
              nxt_new = 1'b0;
            end else if (cmd_full[7:4] == `ADSR_OP_REGISTER_READ_CMD) begin
              nxt_st = adsr_pkg::ADSR_REGISTER_READ_CMD;
              nxt_bit = '0;
              nxt_addr = cmd_full[3:2];
              nxt_left = cmd_full[1:0];
              rd_addr = cmd_full[3:2];
              nxt_rbyte = rd_data;
            end else if (cmd_full[7:4] == `ADSR_OP_REGISTER_WRITE_CMD) begin
              nxt_st = adsr_pkg::ADSR_REGISTER_WRITE_CMD;
              nxt_addr = cmd_full[3:2];
              nxt_left = cmd_full[1:0];
            end else if (cmd_full[7:1] == `ADSR_OP_RESET) begin
              soft_rst = 1'b1;
              nxt_pd = 1'b0;
            end else if (cmd_full[7:1] == `ADSR_OP_SYNC) begin
              start_sync = 1'b1;
              nxt_pd = 1'b0;
            end else if (cmd_full[7:1] == `ADSR_OP_PDOWN) begin
              nxt_pd = 1'b1;
            end
          end
          if (st_ff == adsr_pkg::ADSR_FLUSH && cbit_ff == 3'd7) begin
            if (nxt_st == adsr_pkg::ADSR_FLUSH) begin
              nxt_st = adsr_pkg::ADSR_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Registered state for the serial logic
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= adsr_pkg::ADSR_IDLE;
      buf_ff <= '0;
      shf_ff <= '0;
      cmd_ff <= `ADSR_REG_RST;
      bit_ff <= '0;
      cbit_ff <= '0;
      addr_ff <= '0;
      left_ff <= '0;
      new_ff <= 1'b0;
      rdy_ff <= 1'b1;
      dout_ff <= 1'b1;
      pd_ff <= 1'b0;
      rbyte_ff <= `ADSR_REG_RST;
    end else begin
      st_ff <= nxt_st;
      buf_ff <= nxt_buf;
      shf_ff <= nxt_shf;
      cmd_ff <= nxt_cmd;
      bit_ff <= nxt_bit;
      cbit_ff <= nxt_cbit;
      addr_ff <= nxt_addr;
      left_ff <= nxt_left;
      new_ff <= nxt_new;
      rdy_ff <= nxt_rdy;
      dout_ff <= nxt_dout;
      pd_ff <= nxt_pd;
      rbyte_ff <= nxt_rbyte;
    end
  end

  // Pins: output released when deselected, ready pin always driven
  assign dout_o = dout_ff;
  assign dout_oe = !cs_n;
  assign data_ready_n_pin = rdy_ff;
  assign power_down = pd_ff;

  // Gain is two to the code; bypass honoured only below gain 8
  assign gain_code = all_regs[`ADSR_GAIN_HI:`ADSR_GAIN_LO];
  assign ctl.gain = 8'h01 << gain_code;
  assign ctl.amp_enable = !all_regs[`ADSR_BYPASS_BIT]
                          || (gain_code >= `ADSR_GAIN_AMP_MIN);
  assign ctl.ready_on_output_select = all_regs[8*3+`ADSR_RDYSEL_BIT];
  assign cfg1 = all_regs[15:8];
  assign cfg2 = all_regs[23:16];
  assign cfg3 = all_regs[31:24];
endmodule

// ==== tb/adsr_serial_monitor.sv ====
// Checker on the serial readout block's ports.
// Assumes a bind onto adsr_serial; one clock domain.
`timescale 1ns/1ps
module adsr_serial_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic data_ready_n_pin,
  input wire logic conv_done,
  input wire logic filter_restart,
  input adsr_pkg::adsr_ctl_t ctl,
  input wire logic [7:0] cfg1,
  input wire logic [7:0] cfg2,
  input wire logic [7:0] cfg3
);
  // All checks share the system clock and its reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_oe; dout_oe == !cs_n; endproperty
  a_oe: assert property (p_oe) else $error("pin drive differs from select");
  property p_rdy; conv_done |=> !data_ready_n_pin; endproperty
  a_rdy: assert property (p_rdy) else $error("ready pin not low after result");
  property p_sel; $fell(cs_n) && ctl.ready_on_output_select |=> dout_o == data_ready_n_pin;
  endproperty
  a_sel: assert property (p_sel) else $error("pin not showing ready at select");
  property p_map; ctl.ready_on_output_select == cfg3[1]; endproperty
  a_map: assert property (p_map) else $error("ready select not from register 3");
  property p_gain; $onehot(ctl.gain); endproperty
  a_gain: assert property (p_gain) else $error("gain not a power of two");
  property p_amp; ctl.gain > 8'h04 |-> ctl.amp_enable; endproperty
  a_amp: assert property (p_amp) else $error("amplifier off at high gain");
  property p_rsv; cfg3[0] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_rst; $fell(sys_rst) |-> (cfg1 | cfg2 | cfg3) == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("register not zero after reset");
  property p_fr; filter_restart |=> !filter_restart; endproperty
  a_fr: assert property (p_fr) else $error("restart pulse too long");
endmodule

bind adsr_serial adsr_serial_monitor u_mon (.mclk, .sys_rst, .cs_n, .dout_o, .dout_oe,
  .data_ready_n_pin, .conv_done, .filter_restart, .ctl, .cfg1, .cfg2, .cfg3);

// ==== tb/adsr_host_model.sv ====
// Host serial master: select, serial clock and data in.
// Assumes the bench resolves the shared output line into pin.
`timescale 1ns/1ps
module adsr_host_model #(
  parameter int HALF = 3
) (
  input wire logic mclk,
  input wire logic pin,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  // Idle bus: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Settle time lets the device see select before any clock edge
  task automatic sel(input logic v);
    @(negedge mclk) cs_n = v;
    din = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  // Data set on the rise, taken at the fall; HALF above 2 keeps edges visible
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge mclk);
      sclk = 1'b1;
      din = tx[i];
      repeat (HALF) @(negedge mclk);
      rx[i] = pin;
      sclk = 1'b0;
      repeat (HALF - 1) @(negedge mclk);
    end
  endtask
endmodule

// ==== tb/adsr_serial_tb.sv ====
// Self-checking bench for the serial command and readout block.
// Assumes the host model drives serial pins; the bench feeds results.
`timescale 1ns/1ps
module adsr_serial_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic conv_done = 1'b0;
  logic [23:0] conv_data = 24'h000000;
  logic cs_n, sclk, din, dout_o, dout_oe, data_ready_n_pin, filter_restart;
  logic start_sync, power_down;
  logic [7:0] fr_cnt = 8'h00;
  logic [7:0] sync_cnt = 8'h00;
  logic last_ff = 1'b0;
  logic [7:0] cfg1, cfg2, cfg3, rx;
  logic [7:0] wv [4] = '{8'h5e, 8'ha5, 8'h3c, 8'hff};
  logic [7:0] ev [4] = '{8'h5e, 8'ha5, 8'h3c, 8'hfe};
  adsr_pkg::adsr_ctl_t ctl;
  wire pin;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #25 mclk = ~mclk;
  // Released line shows the inverse of its last level, never a held value
  always @(posedge mclk) if (dout_oe) last_ff <= dout_o;
  assign pin = dout_oe ? dout_o : ~last_ff;
  // Count restart and sync pulses so a short one is not missed
  always @(posedge mclk) if (filter_restart) fr_cnt <= fr_cnt + 8'h01;
  always @(posedge mclk) if (start_sync) sync_cnt <= sync_cnt + 8'h01;
  adsr_host_model u_host (.mclk, .pin, .cs_n, .sclk, .din);
  adsr_serial u_dut (.mclk, .sys_rst, .cs_n, .sclk, .din, .dout_o, .dout_oe,
    .data_ready_n_pin, .conv_done, .conv_data, .filter_restart, .start_sync,
    .power_down, .ctl, .cfg1, .cfg2, .cfg3);
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    u_host.xfer(b, rx);
  endtask
  task automatic rb(input logic [7:0] tx, input logic [7:0] exp);
    u_host.xfer(tx, rx);
    chk("byte out", exp, rx);
  endtask
  task automatic rdy(input logic exp);
    repeat (2) @(negedge mclk);
    chk("ready pin", {7'h00, exp}, {7'h00, data_ready_n_pin});
  endtask
  task automatic cv(input logic [23:0] d);
    @(negedge mclk);
    conv_done = 1'b1;
    conv_data = d;
    @(negedge mclk);
    conv_done = 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard: the run needs about 2900 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    // Registers: reset values, full write, masked bit, gain table, wrap
    u_host.sel(1'b0);
    cmd(8'h23);
    for (int i = 0; i < 4; i++) rb(8'h00, 8'h00);
    cmd(8'h43);
    foreach (wv[i]) cmd(wv[i]);
    repeat (3) @(negedge mclk);
    chk("restart", 8'h01, fr_cnt);
    cmd(8'h23);
    foreach (ev[i]) rb(8'h00, ev[i]);
    chk("cfg3", 8'hfe, cfg3);
    for (int c = 0; c < 8; c++) begin
      cmd(8'h40);
      cmd({4'h0, c[2:0], 1'b1});
      repeat (2) @(negedge mclk);
      chk("gain", 8'h01 << c, ctl.gain);
      chk("amp", {7'h00, c > 2}, {7'h00, ctl.amp_enable});
    end
    cmd(8'h2d);
    rb(8'h00, 8'hfe);
    rb(8'h00, 8'h0f);
    u_host.sel(1'b1);
    chk("oe", 8'h00, {7'h00, dout_oe});
    $display("test registers done");
    // Mid-run reset, then power-down, sync and reset commands
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk("cfg1", 8'h00, cfg1);
    chk("cfg3", 8'h00, cfg3);
    u_host.sel(1'b0);
    cmd(8'h4c);
    cmd(8'h03);
    cmd(8'h02);
    chk("power_down", 8'h01, {7'h00, power_down});
    chk("cfg3", 8'h02, cfg3);
    cmd(8'h08);
    chk("power_down", 8'h00, {7'h00, power_down});
    chk("sync", 8'h01, sync_cnt);
    cmd(8'h06);
    chk("cfg3", 8'h00, cfg3);
    cmd(8'h4c);
    cmd(8'h02);
    u_host.sel(1'b1);
    $display("test reset and power commands done");
    // Stream read aborted by a result command, then newer data mid-read
    cv(24'ha5c396);
    rdy(1'b0);
    u_host.sel(1'b0);
    chk("ready on pin", 8'h00, {7'h00, pin});
    rb(8'h12, 8'ha5);
    rb(8'h00, 8'ha5);
    rb(8'h00, 8'hc3);
    rb(8'h00, 8'h96);
    rdy(1'b1);
    cmd(8'h12);
    rb(8'h00, 8'ha5);
    cv(24'h5a5a5a);
    rb(8'h00, 8'hc3);
    rb(8'h00, 8'h96);
    rdy(1'b0);
    rb(8'h00, 8'hff);
    $display("test result command done");
    // Polled stream read of the unread result, then flush
    u_host.sel(1'b1);
    u_host.sel(1'b0);
    chk("ready on pin", 8'h00, {7'h00, pin});
    for (int i = 0; i < 3; i++) rb(8'h00, 8'h5a);
    rb(8'h00, 8'hff);
    rdy(1'b1);
    u_host.sel(1'b1);
    $display("test stream read done");
    // Register write sent inside a stream read leaves the result intact
    cv(24'h3cc33c);
    u_host.sel(1'b0);
    rb(8'h00, 8'h3c);
    rb(8'h40, 8'hc3);
    rb(8'h0b, 8'h3c);
    chk("restart", 8'h0c, fr_cnt);
    chk("gain", 8'h20, ctl.gain);
    chk("amp", 8'h01, {7'h00, ctl.amp_enable});
    rb(8'h00, 8'hff);
    rdy(1'b1);
    u_host.sel(1'b1);
    $display("test write during read done");
    stop_test();
  end
endmodule
